/* File: flc_defs.svh */
/*
 Constants of the flash command controller: register offsets, flash
 command codes and bus-cycle timing. Assumes a 40 MHz system clock.
*/
`ifndef FLC_DEFS_SVH
`define FLC_DEFS_SVH
// software register offsets
`define FLC_OFF_CMD 8'h00
`define FLC_OFF_ADDR 8'h04
`define FLC_OFF_WDATA 8'h08
`define FLC_OFF_RDATA 8'h0c
`define FLC_OFF_STAT 8'h10
`define FLC_OFF_CTRL 8'h14
// flash command codes
`define FLC_C_ARRAY 8'hff
`define FLC_C_IDENT 8'h90
`define FLC_C_QUERY 8'h98
`define FLC_C_STATUS 8'h70
`define FLC_C_CLEAR 8'h50
`define FLC_C_PROG 8'h40
`define FLC_C_ERASE 8'h20
`define FLC_C_CONFIRM 8'hd0
`define FLC_C_SUSPEND 8'hb0
`define FLC_C_CONFIG 8'h60
`define FLC_C_LOCK 8'h01
`define FLC_C_LOCKDOWN 8'h2f
`define FLC_C_PROT 8'hc0
// status bit of the flash that says its state machine is ready
`define FLC_SR_READY 7
// control register reset value: reset/power-down pin released
`define FLC_CTRL_RST 1'b1
// timing in ns and derived cycle counts (least times round up)
`define FLC_CLK_NS 25
`define FLC_T_WP_NS 50
`define FLC_T_ACC_NS 80
`define FLC_T_HOLD_NS 25
`define FLC_CYC(ns) (((ns) + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_SYNC_CYC 2
`endif

/* File: flc_pkg.sv */
/*
 Types of the flash command controller. Assumes flc_defs.svh beside it.
*/
package flc_pkg;
	// software orders
	typedef enum logic [3:0] {
		OP_READ_ARRAY = 4'h0, OP_READ_IDENT = 4'h1, OP_READ_QUERY = 4'h2,
		OP_READ_STATUS = 4'h3, OP_POLL = 4'h4, OP_CLEAR = 4'h5,
		OP_PROGRAM = 4'h6, OP_ERASE = 4'h7, OP_SUSPEND = 4'h8,
		OP_RESUME = 4'h9, OP_LOCK = 4'ha, OP_UNLOCK = 4'hb,
		OP_LOCKDOWN = 4'hc, OP_PROT = 4'hd
	} flc_op_type;
	// read mode the flash is believed to be in
	typedef enum logic [1:0] {
		MODE_ARRAY = 2'h0, MODE_IDENT = 2'h1, MODE_QUERY = 2'h2,
		MODE_STATUS = 2'h3
	} flc_mode_type;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_W1 = 4'h2, ST_W2 = 4'h4, ST_RD = 4'h8
	} flc_state_type;
	// bus-cycle engine states
	typedef enum logic [3:0] {
		CY_IDLE = 4'h1, CY_SETUP = 4'h2, CY_PULSE = 4'h4, CY_HOLD = 4'h8
	} flc_cyc_state_type;
endpackage : flc_pkg

/* File: flc_cyc_if.sv */
/*
 Request and answer between sequencer and bus-cycle engine.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface flc_cyc_if #(parameter int AW = 22);
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic done;
	modport master(output req, wr, addr, wdata, input rdata, done);
	modport engine(input req, wr, addr, wdata, output rdata, done);
endinterface : flc_cyc_if

/* File: flc_cycle.sv */
/*
 Bus-cycle engine: one asynchronous flash write or read per request.
 Assumes the flash data pins are outside the clock domain.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
module flc_cycle import flc_pkg::*; #(
	parameter int AW = 22,
	parameter int WP_CYC = `FLC_CYC(`FLC_T_WP_NS),
	parameter int ACC_CYC = `FLC_CYC(`FLC_T_ACC_NS),
	parameter int HOLD_CYC = `FLC_CYC(`FLC_T_HOLD_NS)
) (
	input wire logic clk,
	input wire logic rstn,
	flc_cyc_if.engine cyc,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [AW-1:0] fa,
	output logic [15:0] dq_o,
	output logic dq_oe,
	input wire logic [15:0] dq_i
);
	flc_cyc_state_type st_r;
	logic [7:0] cnt_r;
	logic wr_r;
	logic [15:0] dq_s1_r;
	logic [15:0] dq_s2_r;
	logic [15:0] rdata_r;

	// pins are asynchronous to us: two flops before use
	always_ff @(posedge clk) begin
		dq_s1_r <= dq_i;
		dq_s2_r <= dq_s1_r;
	end

	// phase sequencing; the read pulse is stretched by the synchroniser
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= CY_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
		end else begin
			case (st_r)
				CY_IDLE: begin
					if (cyc.req) begin
						st_r <= CY_SETUP;
						wr_r <= cyc.wr;
					end
				end
				CY_SETUP: begin
					st_r <= CY_PULSE;
					cnt_r <= wr_r ? 8'(WP_CYC - 1) :
						8'(ACC_CYC + `FLC_SYNC_CYC - 1);
				end
				CY_PULSE: begin
					if (cnt_r == 8'h00) begin
						st_r <= CY_HOLD;
						cnt_r <= 8'(HOLD_CYC - 1);
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				CY_HOLD: begin
					if (cnt_r == 8'h00) begin
						st_r <= CY_IDLE;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: st_r <= CY_IDLE;
			endcase
		end
	end

	// address and data latched at request, held through the hold phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			fa <= '0;
			dq_o <= 16'h0000;
		end else if (st_r == CY_IDLE && cyc.req) begin
			fa <= cyc.addr;
			dq_o <= cyc.wdata;
		end
	end

	// pin strobes from flops so they never glitch
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			dq_oe <= 1'b0;
		end else begin
			ce_n <= !(st_r == CY_SETUP || st_r == CY_PULSE ||
				(st_r == CY_HOLD && cnt_r != 8'h00));
			we_n <= !(wr_r && (st_r == CY_SETUP ||
				(st_r == CY_PULSE && cnt_r != 8'h00)));
			oe_n <= !(!wr_r && (st_r == CY_SETUP ||
				(st_r == CY_PULSE && cnt_r != 8'h00)));
			dq_oe <= wr_r && st_r != CY_IDLE;
		end
	end

	// sample read data at the end of the stretched pulse
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_r <= 16'h0000;
		end else if (st_r == CY_PULSE && cnt_r == 8'h00 && !wr_r) begin
			rdata_r <= dq_s2_r;
		end
	end

	assign cyc.rdata = rdata_r;
	assign cyc.done = (st_r == CY_HOLD) && (cnt_r == 8'h00);

	we_in_ce_a: assert property (
		@(posedge clk) disable iff (!rstn) !we_n |-> !ce_n)
		else $error("write strobe low outside chip select");
	no_fight_a: assert property (
		@(posedge clk) disable iff (!rstn) !oe_n |-> !dq_oe)
		else $error("output enable low while data driven");
	we_width_a: assert property (
		@(posedge clk) disable iff (!rstn)
		$fell(we_n) |-> !we_n ##1 !we_n ##1 we_n) // two low cycles
		else $error("write pulse width wrong");
	data_hold_a: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(we_n) |-> dq_oe && !ce_n && $stable(dq_o) && $stable(fa))
		else $error("address or data moved at write edge");
endmodule : flc_cycle

/* File: flc_ctrl.sv */
/*
 Host-side flash command controller: turns software orders into flash
 command sequences. Assumes a flash with asynchronous parallel pins.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
module flc_ctrl import flc_pkg::*; #(
	parameter int AW = 22
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic reset_powerdown_n,
	output logic [AW-1:0] fa,
	output logic [15:0] dq_o,
	output logic dq_oe,
	input wire logic [15:0] dq_i
);
	flc_cyc_if #(.AW(AW)) cyc();
	flc_state_type st_r;
	flc_mode_type mode_r;
	flc_op_type op;
	logic [AW-1:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic [7:0] status_r;
	logic [7:0] code1_r;
	logic [15:0] data2_r;
	logic need_w1;
	logic need_w2;
	logic need_rd;
	logic w2_r;
	logic rd_r;
	logic issued_r;
	logic running_r;
	logic refused_r;
	logic ctrl_r;
	logic cmd_wr;
	logic allowed;
	logic accept;
	logic [7:0] c1;
	logic [15:0] d2;

	flc_cycle #(.AW(AW)) u_cycle (
		.clk(clk),
		.rstn(rstn),
		.cyc(cyc),
		.ce_n(ce_n),
		.we_n(we_n),
		.oe_n(oe_n),
		.fa(fa),
		.dq_o(dq_o),
		.dq_oe(dq_oe),
		.dq_i(dq_i)
	);

	assign op = flc_op_type'(sw_wdata[3:0]);
	assign cmd_wr = sw_wr && sw_addr == `FLC_OFF_CMD;
	// while the flash runs it takes only status and suspend orders
	assign allowed = !running_r || op == OP_READ_STATUS ||
		op == OP_POLL || op == OP_SUSPEND;
	assign accept = cmd_wr && st_r == ST_IDLE && allowed && ctrl_r;

	// decode an order into first code, second word and a trailing read
	always_comb begin
		c1 = `FLC_C_ARRAY;
		d2 = wdata_r;
		need_w1 = 1'b1;
		need_w2 = 1'b0;
		need_rd = 1'b0;
		case (op)
			OP_READ_ARRAY: begin
				need_w1 = mode_r != MODE_ARRAY;
				need_rd = 1'b1;
			end
			OP_READ_IDENT: begin
				c1 = `FLC_C_IDENT;
				need_rd = 1'b1;
			end
			OP_READ_QUERY: begin
				c1 = `FLC_C_QUERY;
				need_rd = 1'b1;
			end
			OP_READ_STATUS: begin
				c1 = `FLC_C_STATUS;
				need_rd = 1'b1;
			end
			OP_POLL: begin
				need_w1 = 1'b0;
				need_rd = 1'b1;
			end
			OP_CLEAR: c1 = `FLC_C_CLEAR;
			OP_PROGRAM: begin
				c1 = `FLC_C_PROG;
				need_w2 = 1'b1;
			end
			OP_ERASE: begin
				c1 = `FLC_C_ERASE;
				d2 = {8'h00, `FLC_C_CONFIRM};
				need_w2 = 1'b1;
			end
			OP_SUSPEND: c1 = `FLC_C_SUSPEND;
			OP_RESUME: c1 = `FLC_C_CONFIRM;
			OP_LOCK: begin
				c1 = `FLC_C_CONFIG;
				d2 = {8'h00, `FLC_C_LOCK};
				need_w2 = 1'b1;
			end
			OP_UNLOCK: begin
				c1 = `FLC_C_CONFIG;
				d2 = {8'h00, `FLC_C_CONFIRM};
				need_w2 = 1'b1;
			end
			OP_LOCKDOWN: begin
				c1 = `FLC_C_CONFIG;
				d2 = {8'h00, `FLC_C_LOCKDOWN};
				need_w2 = 1'b1;
			end
			OP_PROT: begin
				c1 = `FLC_C_PROT;
				need_w2 = 1'b1;
			end
			default: need_w1 = 1'b0;
		endcase
	end

	// sequencer: first write, second write, read, each only if needed
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			code1_r <= `FLC_C_ARRAY;
			data2_r <= 16'h0000;
			w2_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (accept) begin
						code1_r <= c1;
						data2_r <= d2;
						w2_r <= need_w2;
						rd_r <= need_rd;
						st_r <= need_w1 ? ST_W1 : (need_rd ? ST_RD : ST_IDLE);
					end
				end
				ST_W1: begin
					if (cyc.done) begin
						st_r <= w2_r ? ST_W2 : (rd_r ? ST_RD : ST_IDLE);
					end
				end
				ST_W2: begin
					if (cyc.done) begin
						st_r <= ST_IDLE;
					end
				end
				ST_RD: begin
					if (cyc.done) begin
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// one request per bus cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			issued_r <= 1'b0;
		end else if (cyc.done) begin
			issued_r <= 1'b0;
		end else if (cyc.req) begin
			issued_r <= 1'b1;
		end
	end
	assign cyc.req = st_r != ST_IDLE && !issued_r && !cyc.done;
	assign cyc.wr = st_r != ST_RD;
	assign cyc.addr = addr_r;
	assign cyc.wdata = st_r == ST_W2 ? data2_r : {8'h00, code1_r};

	// believed read mode; program and erase leave the flash in status
	always_ff @(posedge clk) begin
		if (!rstn || !ctrl_r) begin
			mode_r <= MODE_ARRAY;
		end else if (accept && need_w1) begin
			case (c1)
				`FLC_C_ARRAY: mode_r <= MODE_ARRAY;
				`FLC_C_IDENT: mode_r <= MODE_IDENT;
				`FLC_C_QUERY: mode_r <= MODE_QUERY;
				`FLC_C_CLEAR, `FLC_C_CONFIG: mode_r <= mode_r;
				default: mode_r <= MODE_STATUS;
			endcase
		end
	end

	// the flash is busy from a start until a status read shows ready
	always_ff @(posedge clk) begin
		if (!rstn || !ctrl_r) begin
			running_r <= 1'b0;
		end else if (accept && (op == OP_PROGRAM || op == OP_ERASE ||
			op == OP_PROT || op == OP_RESUME)) begin
			running_r <= 1'b1;
		end else if (st_r == ST_RD && cyc.done && mode_r == MODE_STATUS &&
			cyc.rdata[`FLC_SR_READY]) begin
			running_r <= 1'b0;
		end
	end

	// read results; the last status byte keeps the flash's error flags
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_r <= 16'h0000;
			status_r <= 8'h00;
		end else if (st_r == ST_RD && cyc.done) begin
			rdata_r <= cyc.rdata;
			if (mode_r == MODE_STATUS) begin
				status_r <= cyc.rdata[7:0];
			end
		end
	end

	// software registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_r <= '0;
			wdata_r <= 16'h0000;
			ctrl_r <= `FLC_CTRL_RST;
			refused_r <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == `FLC_OFF_ADDR) begin
				addr_r <= sw_wdata[AW-1:0];
			end else if (sw_wr && sw_addr == `FLC_OFF_WDATA) begin
				wdata_r <= sw_wdata[15:0];
			end else if (sw_wr && sw_addr == `FLC_OFF_CTRL) begin
				ctrl_r <= sw_wdata[0];
			end
			if (cmd_wr) begin
				refused_r <= !accept;
			end
		end
	end
	assign reset_powerdown_n = ctrl_r;

	// read answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sw_rdata <= 32'h0000_0000;
		end else if (sw_rd) begin
			if (sw_addr == `FLC_OFF_ADDR) begin
				sw_rdata <= 32'(addr_r);
			end else if (sw_addr == `FLC_OFF_WDATA) begin
				sw_rdata <= {16'h0000, wdata_r};
			end else if (sw_addr == `FLC_OFF_RDATA) begin
				sw_rdata <= {16'h0000, rdata_r};
			end else if (sw_addr == `FLC_OFF_STAT) begin
				sw_rdata <= {16'h0000, status_r, 2'b00, mode_r, 1'b0,
					refused_r, running_r, st_r != ST_IDLE};
			end else if (sw_addr == `FLC_OFF_CTRL) begin
				sw_rdata <= {31'h0000_0000, ctrl_r};
			end else begin
				sw_rdata <= 32'h0000_0000;
			end
		end else begin
			sw_rdata <= 32'h0000_0000;
		end
	end

	refuse_busy_a: assert property (
		@(posedge clk) disable iff (!rstn)
		cmd_wr && running_r && !allowed |=> refused_r && st_r == ST_IDLE)
		else $error("order taken while flash busy");
	prog_status_a: assert property (
		@(posedge clk) disable iff (!rstn)
		accept && op == OP_PROGRAM |=> mode_r == MODE_STATUS && running_r)
		else $error("program did not enter status mode");
	array_prefix_a: assert property (
		@(posedge clk) disable iff (!rstn)
		accept && op == OP_READ_ARRAY && mode_r != MODE_ARRAY |=>
		st_r == ST_W1 && code1_r == `FLC_C_ARRAY)
		else $error("array read without array command");
	clear_code_a: assert property (
		@(posedge clk) disable iff (!rstn)
		accept && op == OP_CLEAR |=> code1_r == `FLC_C_CLEAR && !w2_r)
		else $error("clear status code wrong");
	erase_pair_a: assert property (
		@(posedge clk) disable iff (!rstn)
		accept && op == OP_ERASE |=> code1_r == `FLC_C_ERASE &&
		data2_r[7:0] == `FLC_C_CONFIRM && w2_r)
		else $error("erase pair wrong");
	powerdown_a: assert property (
		@(posedge clk) disable iff (!rstn)
		!ctrl_r |-> !reset_powerdown_n ##1
		(!running_r && mode_r == MODE_ARRAY))
		else $error("power-down did not clear state");
	unlock_pair_a: assert property (
		@(posedge clk) disable iff (!rstn)
		accept && op == OP_UNLOCK |=> code1_r == `FLC_C_CONFIG &&
		data2_r[7:0] == `FLC_C_CONFIRM)
		else $error("unlock pair wrong");
endmodule : flc_ctrl

/* File: flc_flash_model.sv */
/* behavioural flash device for the controller bench.
 assumes split data pins and writes taken while chip select is low. */
`timescale 1ns/10ps
module flc_flash_model #(
	parameter int AW = 22,
	parameter logic [15:0] ID_WORD = 16'h00a5, // arbitrary value
	parameter logic [15:0] QRY_WORD = 16'h0051
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic rp_n,
	input wire logic [AW-1:0] fa,
	input wire logic [15:0] dq_o,
	output logic [15:0] dq_i
);
	logic [15:0] mem [16];
	logic [1:0] lk [16];
	logic [1:0] mode;
	logic [7:0] setup, s, err, stat, c;
	logic ers, susp;
	logic [15:0] q, last_q;
	int busy;
	// status byte; ready also shows while suspended
	assign stat = {busy == 0 || susp, ers & susp, err[5:4], 1'b0,
		~ers & susp, err[1], 1'b0};
	// power-up state: array reads, no setup pending, flags clear
	initial begin
		last_q = 16'h0000;
		mode = 2'h0;
		setup = 8'h00;
		err = 8'h00;
		susp = 1'b0;
		ers = 1'b0;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'hffff;
			lk[i] = 2'h0;
		end
	end
	// commands land on the rising write-enable edge
	always @(posedge we_n or negedge rp_n) begin
		if (!rp_n) begin
			mode = 2'h0;
			setup = 8'h00;
			err = 8'h00;
			busy = 0;
			susp = 1'b0;
			ers = 1'b0;
		end else if (!ce_n) begin
			c = dq_o[7:0];
			s = setup;
			setup = 8'h00;
			if (s == 8'h40 || s == 8'hc0) begin
				if (lk[fa[3:0]] != 2'h0 && s == 8'h40) err[1] = 1'b1;
				else begin
					mem[fa[3:0]] &= dq_o;
					busy = 2;
					ers = 1'b0;
				end
				mode = 2'h3;
			end else if (s == 8'h20) begin
				mode = 2'h3;
				if (c != 8'hd0) err[5:4] = 2'h3;
				else begin
					for (int i = 0; i < 16; i++)
						if (i[3:2] == fa[3:2] && lk[i] == 2'h0) mem[i] = 16'hffff;
					busy = 4;
					ers = 1'b1;
				end
			end else if (s == 8'h60) begin
				if (c == 8'h01) lk[fa[3:0]] = 2'h1;
				else if (c == 8'h2f) lk[fa[3:0]] = 2'h2;
				else if (c != 8'hd0) err[5:4] = 2'h3;
				else if (lk[fa[3:0]] != 2'h2) lk[fa[3:0]] = 2'h0;
			end else if (busy != 0 && !susp) begin
				if (c == 8'h70) mode = 2'h3;
				if (c == 8'hb0) susp = 1'b1;
			end else case (c)
				8'hff: mode = 2'h0;
				8'h90: mode = 2'h1;
				8'h98: mode = 2'h2;
				8'h70: mode = 2'h3;
				8'h50: err = 8'h00;
				8'hd0: if (susp) begin
					susp = 1'b0;
					mode = 2'h3;
				end
				8'h10: setup = 8'h40;
				8'h40, 8'h20, 8'h60, 8'hc0: setup = c;
				default: ;
			endcase
		end
	end
	// status reads wear down a running job; a suspended one stays put
	always @(posedge oe_n) begin
		last_q = q;
		if (!ce_n && mode == 2'h3 && busy > 0 && !susp) busy--;
	end
	// status whatever the address; released pins show the inverse word
	assign q = mode == 2'h0 ? mem[fa[3:0]] : mode == 2'h1 ? ID_WORD :
		mode == 2'h2 ? QRY_WORD : {8'h00, stat};
	assign dq_i = (!ce_n && !oe_n) ? q : ~last_q;
endmodule : flc_flash_model

/* File: tb.sv */
/* self-checking bench of the flash command controller.
 assumes the flash model beside it and a 40 MHz clock. */
`timescale 1ns/10ps
`include "flc_defs.svh"
module tb import flc_pkg::*; ;
	typedef struct packed {
		flc_op_type op;
		logic [1:0] mode;
		logic [15:0] q;
	} flc_row_type;
	logic clk, rstn, sw_wr, sw_rd, ce_n, we_n, oe_n, rp_n, dq_oe;
	logic [7:0] sw_addr;
	logic [31:0] sw_wdata, sw_rdata, d;
	logic [21:0] fa;
	logic [15:0] dq_o, dq_i;
	int fails = 0, n_tests = 0, cyc = 0;
	flc_row_type rows [4];
	flc_ctrl #(.AW(22)) u_dut (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.reset_powerdown_n(rp_n), .fa(fa), .dq_o(dq_o), .dq_oe(dq_oe),
		.dq_i(dq_i));
	flc_flash_model #(.AW(22)) u_flash (.ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .rp_n(rp_n), .fa(fa), .dq_o(dq_o), .dq_i(dq_i));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask : rd
	// order, then wait on the busy bit under a bound
	task automatic op(input flc_op_type o);
		wr(`FLC_OFF_CMD, 32'(o));
		for (int i = 0; i < 100; i++) begin
			rd(`FLC_OFF_STAT);
			if (d[0] === 1'b0) break;
		end
	endtask : op
	// poll until the ready bit shows, then compare the status byte
	task automatic pchk(input logic [7:0] e);
		for (int i = 0; i < 20; i++) begin
			op(OP_POLL);
			rd(`FLC_OFF_RDATA);
			if (d[7] === 1'b1) break;
		end
		chk(32'(d[7:0]), 32'(e));
	endtask : pchk
	task automatic mchk(input logic [1:0] m);
		rd(`FLC_OFF_STAT);
		chk(32'(d[5:4]), 32'(m));
	endtask : mchk
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, well above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		rows[0] = '{OP_READ_IDENT, 2'h1, 16'h00a5};
		rows[1] = '{OP_READ_QUERY, 2'h2, 16'h0051};
		rows[2] = '{OP_READ_ARRAY, 2'h0, 16'hffff};
		rows[3] = '{OP_READ_STATUS, 2'h3, 16'h0080};
		rstn = 1'b0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		sw_addr = 8'h00;
		sw_wdata = 32'h0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(`FLC_OFF_STAT);
		chk(d, 32'h0);
		chk(32'(rp_n), 32'h1);
		rd(8'h20);
		chk(d, 32'h0);
		wr(`FLC_OFF_ADDR, 32'h3);
		foreach (rows[i]) begin
			op(OP_READ_ARRAY);
			mchk(2'h0);
			op(rows[i].op);
			mchk(rows[i].mode);
			rd(`FLC_OFF_RDATA);
			chk(32'(d[15:0]), 32'(rows[i].q));
		end
		$display("test modes done");
		wr(`FLC_OFF_WDATA, 32'h1234);
		op(OP_PROGRAM);
		mchk(2'h3);
		pchk(8'h80);
		op(OP_READ_ARRAY);
		rd(`FLC_OFF_RDATA);
		chk(32'(d[15:0]), 32'h1234);
		op(OP_PROGRAM);
		wr(`FLC_OFF_CMD, 32'(OP_READ_IDENT));
		rd(`FLC_OFF_STAT);
		chk(32'(d[2]), 32'h1);
		pchk(8'h80);
		$display("test program done");
		op(OP_ERASE);
		mchk(2'h3);
		op(OP_SUSPEND);
		pchk(8'hc0);
		repeat (40) @(posedge clk);
		pchk(8'hc0);
		op(OP_RESUME);
		pchk(8'h80);
		op(OP_READ_ARRAY);
		rd(`FLC_OFF_RDATA);
		chk(32'(d[15:0]), 32'hffff);
		$display("test erase done");
		wr(`FLC_OFF_ADDR, 32'h5);
		op(OP_LOCK);
		op(OP_PROGRAM);
		pchk(8'h82);
		op(OP_CLEAR);
		pchk(8'h80);
		op(OP_UNLOCK);
		op(OP_PROGRAM);
		pchk(8'h80);
		op(OP_LOCKDOWN);
		op(OP_UNLOCK);
		op(OP_PROGRAM);
		pchk(8'h82);
		wr(`FLC_OFF_ADDR, 32'h4);
		op(OP_PROGRAM);
		pchk(8'h82);
		op(OP_PROT);
		mchk(2'h3);
		pchk(8'h82);
		$display("test locks done");
		wr(`FLC_OFF_CTRL, 32'h0);
		@(posedge clk);
		#1 chk(32'(rp_n), 32'h0);
		mchk(2'h0);
		wr(`FLC_OFF_CTRL, 32'h1);
		op(OP_READ_STATUS);
		rd(`FLC_OFF_RDATA);
		chk(32'(d[7:0]), 32'h80);
		$display("test power-down done");
		stop_test();
	end
endmodule : tb
